// ===== verilog/arts_pkg.sv
`default_nettype none
package arts_pkg;
	// register addresses on the special-function-register bus
	localparam logic [7:0] ADDR_TIMER_CONTROL = 8'h91;
	localparam logic [7:0] ADDR_RELOAD_LOW = 8'h92;
	localparam logic [7:0] ADDR_RELOAD_HIGH = 8'h93;
	localparam logic [7:0] ADDR_COUNT_LOW = 8'h94;
	localparam logic [7:0] ADDR_COUNT_HIGH = 8'h95;

	// timer_control field positions
	localparam int CTL_HIGH_FLAG = 7;
	localparam int CTL_LOW_FLAG = 6;
	localparam int CTL_LOW_IRQ_EN = 5;
	localparam int CTL_SPLIT = 3;
	localparam int CTL_RUN = 2;
	localparam int CTL_EXT_SEL = 0;

	// reset values
	localparam logic [7:0] RST_TIMER_CONTROL = 8'h00;
	localparam logic [7:0] RST_RELOAD_LOW = 8'h00;
	localparam logic [7:0] RST_RELOAD_HIGH = 8'h00;
	localparam logic [7:0] RST_COUNT = 8'h00;
	localparam logic [7:0] RST_READ_DATA = 8'h00;
	localparam logic [3:0] RST_SYS_DIV = 4'h0;
	localparam logic [2:0] RST_EXT_DIV = 3'h0;
	localparam logic RST_SYNC = 1'h0;

	// byte values
	localparam logic [7:0] BYTE_ALL_ONES = 8'hff;
	localparam logic [7:0] BYTE_ZERO = 8'h00;

	// prescaler counts
	localparam int SYS_DIV = 12;
	localparam int EXT_DIV = 8;
	localparam logic [3:0] SYS_DIV_LAST = 4'(SYS_DIV - 1);
	localparam logic [2:0] EXT_DIV_LAST = 3'(EXT_DIV - 1);
	localparam logic [3:0] SYS_DIV_FIRST = 4'h0;
endpackage
`default_nettype wire

// ===== verilog/arts_timer.sv
`timescale 1ns/1ps
`default_nettype none
module arts_timer (
	// clock and reset
	input wire logic clk,
	input wire logic reset,
	// special-function-register bus
	input wire logic [7:0] sfr_addr,
	input wire logic sfr_wr,
	input wire logic [7:0] sfr_wdata,
	input wire logic sfr_rd,
	output logic [7:0] sfr_rdata,
	// configuration held outside this block
	input wire logic high_byte_clock_select,
	input wire logic low_byte_clock_select,
	input wire logic capture_enable,
	input wire logic timer_irq_enable,
	// external clock source
	input wire logic ext_clock,
	// interrupt request
	output logic irq
);
	import arts_pkg::*;

	// control register bits
	logic high_flag_ff;
	logic low_flag_ff;
	logic low_irq_en_ff;
	logic split_ff;
	logic run_ff;
	logic ext_sel_ff;
	logic nxt_high_flag;
	logic nxt_low_flag;
	logic nxt_low_irq_en;
	logic nxt_split;
	logic nxt_run;
	logic nxt_ext_sel;
	// reload and count bytes
	logic [7:0] reload_low_ff;
	logic [7:0] reload_high_ff;
	logic [7:0] nxt_reload_low;
	logic [7:0] nxt_reload_high;
	logic [7:0] count_low_ff;
	logic [7:0] count_high_ff;
	logic [7:0] nxt_count_low;
	logic [7:0] nxt_count_high;
	// ticks, modes and counting events
	logic sys_tick;
	logic ext_rise;
	logic ext_tick;
	logic slow_tick;
	logic tick_low;
	logic tick_high;
	logic mode16;
	logic mode8;
	logic low_at_top;
	logic high_at_top;
	logic inc16;
	logic inc_low8;
	logic inc_high8;
	logic wrap16;
	logic low_roll;
	logic high_roll;
	logic [7:0] low_plus1;
	logic [7:0] high_plus1;
	// read path
	logic [7:0] ctl_word;
	logic [7:0] rd_sel_data;
	logic [7:0] rdata_ff;
	logic [7:0] nxt_rdata;
	// prescalers and synchroniser
	logic [3:0] sys_div_ff;
	logic [3:0] nxt_sys_div;
	logic [2:0] ext_div_ff;
	logic [2:0] nxt_ext_div;
	logic ext_sync1_ff;
	logic ext_sync2_ff;
	logic ext_prev_ff;
	logic nxt_ext_sync1;
	logic nxt_ext_sync2;
	logic nxt_ext_prev;

	// address decode
	wire logic sel_ctl = (sfr_addr == ADDR_TIMER_CONTROL);
	wire logic sel_rll = (sfr_addr == ADDR_RELOAD_LOW);
	wire logic sel_rlh = (sfr_addr == ADDR_RELOAD_HIGH);
	wire logic sel_cl = (sfr_addr == ADDR_COUNT_LOW);
	wire logic sel_ch = (sfr_addr == ADDR_COUNT_HIGH);
	wire logic wr_ctl = sfr_wr && sel_ctl;
	wire logic wr_rll = sfr_wr && sel_rll;
	wire logic wr_rlh = sfr_wr && sel_rlh;
	wire logic wr_cl = sfr_wr && sel_cl;
	wire logic wr_ch = sfr_wr && sel_ch;

	// prescaler ticks
	assign sys_tick = (sys_div_ff == SYS_DIV_LAST);
	// only the second synchroniser stage and its delayed copy feed the edge detect
	assign ext_rise = ext_sync2_ff && !ext_prev_ff;
	assign ext_tick = ext_rise && (ext_div_ff == EXT_DIV_LAST);
	assign slow_tick = ext_sel_ff ? ext_tick : sys_tick;
	assign tick_low = low_byte_clock_select ? 1'h1 : slow_tick;
	assign tick_high = high_byte_clock_select ? 1'h1 : slow_tick;

	// mode and enables; capture mode is not handled here, so the split-mode counters hold in it while 16-bit mode ignores capture_enable
	assign mode16 = !split_ff;
	assign mode8 = split_ff && !capture_enable;
	assign low_at_top = (count_low_ff == BYTE_ALL_ONES);
	assign high_at_top = (count_high_ff == BYTE_ALL_ONES);
	// 16-bit mode follows the low-byte clock select
	assign inc16 = mode16 && run_ff && tick_low;
	assign inc_low8 = mode8 && tick_low;
	assign inc_high8 = mode8 && run_ff && tick_high;
	assign wrap16 = inc16 && low_at_top && high_at_top;
	assign low_roll = (inc16 || inc_low8) && low_at_top;
	assign high_roll = wrap16 || (inc_high8 && high_at_top);

	// incremented bytes; the carry out of the top is dropped on purpose
	assign low_plus1 = count_low_ff + 8'h01;
	assign high_plus1 = count_high_ff + 8'h01;

	// counters: a software write to a counter byte wins over counting
	always_comb begin
		nxt_count_low = count_low_ff;
		if (wrap16) begin
			nxt_count_low = reload_low_ff;
		end else if (inc16) begin
			nxt_count_low = low_plus1;
		end else if (inc_low8) begin
			nxt_count_low = low_at_top ? reload_low_ff : low_plus1;
		end
		if (wr_cl) begin
			nxt_count_low = sfr_wdata;
		end
	end

	// in 16-bit mode the high byte only moves on a carry out of the low byte
	always_comb begin
		nxt_count_high = count_high_ff;
		if (wrap16) begin
			nxt_count_high = reload_high_ff;
		end else if (inc16 && low_at_top) begin
			nxt_count_high = high_plus1;
		end else if (inc_high8) begin
			nxt_count_high = high_at_top ? reload_high_ff : high_plus1;
		end
		if (wr_ch) begin
			nxt_count_high = sfr_wdata;
		end
	end

	// flags: hardware only sets, software write stores; a set in the same cycle wins
	assign nxt_high_flag = high_roll || (wr_ctl ? sfr_wdata[CTL_HIGH_FLAG] : high_flag_ff);
	assign nxt_low_flag = low_roll || (wr_ctl ? sfr_wdata[CTL_LOW_FLAG] : low_flag_ff);

	// remaining control bits change only on a control write
	assign nxt_low_irq_en = wr_ctl ? sfr_wdata[CTL_LOW_IRQ_EN] : low_irq_en_ff;
	assign nxt_split = wr_ctl ? sfr_wdata[CTL_SPLIT] : split_ff;
	assign nxt_run = wr_ctl ? sfr_wdata[CTL_RUN] : run_ff;
	assign nxt_ext_sel = wr_ctl ? sfr_wdata[CTL_EXT_SEL] : ext_sel_ff;

	// reload bytes
	assign nxt_reload_low = wr_rll ? sfr_wdata : reload_low_ff;
	assign nxt_reload_high = wr_rlh ? sfr_wdata : reload_high_ff;

	// combined request stays up while an enabled flag is set
	assign irq = timer_irq_enable && (high_flag_ff || (low_irq_en_ff && low_flag_ff));

	// control byte as read back; spare bits 4 and 1 stay zero
	always_comb begin
		ctl_word = BYTE_ZERO;
		ctl_word[CTL_HIGH_FLAG] = high_flag_ff;
		ctl_word[CTL_LOW_FLAG] = low_flag_ff;
		ctl_word[CTL_LOW_IRQ_EN] = low_irq_en_ff;
		ctl_word[CTL_SPLIT] = split_ff;
		ctl_word[CTL_RUN] = run_ff;
		ctl_word[CTL_EXT_SEL] = ext_sel_ff;
	end

	// read select; unmapped addresses read zero, and the data holds until the next read
	assign rd_sel_data = sel_ctl ? ctl_word :
		sel_rll ? reload_low_ff :
		sel_rlh ? reload_high_ff :
		sel_cl ? count_low_ff :
		sel_ch ? count_high_ff :
		BYTE_ZERO;
	assign nxt_rdata = sfr_rd ? rd_sel_data : rdata_ff;
	assign sfr_rdata = rdata_ff;

	// prescalers run freely from reset and are shared by both bytes
	assign nxt_sys_div = sys_tick ? SYS_DIV_FIRST : sys_div_ff + 4'h1;
	assign nxt_ext_div = ext_rise ? ext_div_ff + 3'h1 : ext_div_ff;

	// two-stage synchroniser; the external clock must run below half of clk
	assign nxt_ext_sync1 = ext_clock;
	assign nxt_ext_sync2 = ext_sync1_ff;
	assign nxt_ext_prev = ext_sync2_ff;

	// control register bits
	always_ff @(posedge clk) begin
		if (reset) begin
			high_flag_ff <= RST_TIMER_CONTROL[CTL_HIGH_FLAG];
		end else begin
			high_flag_ff <= nxt_high_flag;
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			low_flag_ff <= RST_TIMER_CONTROL[CTL_LOW_FLAG];
		end else begin
			low_flag_ff <= nxt_low_flag;
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			low_irq_en_ff <= RST_TIMER_CONTROL[CTL_LOW_IRQ_EN];
		end else begin
			low_irq_en_ff <= nxt_low_irq_en;
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			split_ff <= RST_TIMER_CONTROL[CTL_SPLIT];
		end else begin
			split_ff <= nxt_split;
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			run_ff <= RST_TIMER_CONTROL[CTL_RUN];
		end else begin
			run_ff <= nxt_run;
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			ext_sel_ff <= RST_TIMER_CONTROL[CTL_EXT_SEL];
		end else begin
			ext_sel_ff <= nxt_ext_sel;
		end
	end

	// reload bytes
	always_ff @(posedge clk) begin
		if (reset) begin
			reload_low_ff <= RST_RELOAD_LOW;
		end else begin
			reload_low_ff <= nxt_reload_low;
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			reload_high_ff <= RST_RELOAD_HIGH;
		end else begin
			reload_high_ff <= nxt_reload_high;
		end
	end

	// counter bytes
	always_ff @(posedge clk) begin
		if (reset) begin
			count_low_ff <= RST_COUNT;
		end else begin
			count_low_ff <= nxt_count_low;
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			count_high_ff <= RST_COUNT;
		end else begin
			count_high_ff <= nxt_count_high;
		end
	end

	// read data
	always_ff @(posedge clk) begin
		if (reset) begin
			rdata_ff <= RST_READ_DATA;
		end else begin
			rdata_ff <= nxt_rdata;
		end
	end

	// prescalers
	always_ff @(posedge clk) begin
		if (reset) begin
			sys_div_ff <= RST_SYS_DIV;
		end else begin
			sys_div_ff <= nxt_sys_div;
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			ext_div_ff <= RST_EXT_DIV;
		end else begin
			ext_div_ff <= nxt_ext_div;
		end
	end

	// synchroniser and edge detect stages
	always_ff @(posedge clk) begin
		if (reset) begin
			ext_sync1_ff <= RST_SYNC;
		end else begin
			ext_sync1_ff <= nxt_ext_sync1;
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			ext_sync2_ff <= RST_SYNC;
		end else begin
			ext_sync2_ff <= nxt_ext_sync2;
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			ext_prev_ff <= RST_SYNC;
		end else begin
			ext_prev_ff <= nxt_ext_prev;
		end
	end
endmodule
`default_nettype wire

// ===== tb/arts_timer_sva.sv
`timescale 1ns/1ps
`default_nettype none
module arts_chk
	import arts_pkg::*;
(
	// register bus
	input wire logic clk,
	input wire logic reset,
	input wire logic [7:0] sfr_addr,
	input wire logic sfr_wr,
	input wire logic [7:0] sfr_wdata,
	input wire logic sfr_rd,
	input wire logic [7:0] sfr_rdata,
	// interrupt
	input wire logic timer_irq_enable,
	input wire logic irq
);
	default clocking @(posedge clk); endclocking
	default disable iff (reset);
	wire cw = sfr_wr && sfr_addr == ADDR_TIMER_CONTROL;
	wire cr = sfr_rd && sfr_addr == ADDR_TIMER_CONTROL;
	wire fs = cw && sfr_wdata[CTL_HIGH_FLAG];
	wire un = sfr_addr < ADDR_TIMER_CONTROL || sfr_addr > ADDR_COUNT_HIGH;
	a_irq_gated: assert property (!timer_irq_enable |-> !irq)
		else $error("irq while disabled");
	a_rdata_holds: assert property (!$past(sfr_rd) |-> $stable(sfr_rdata))
		else $error("read data moved");
	a_spare_zero: assert property (cr |=> !sfr_rdata[4] && !sfr_rdata[1])
		else $error("spare bits set");
	a_unmapped_zero: assert property (sfr_rd && un |=> sfr_rdata == 8'h00)
		else $error("unmapped read not zero");
	a_flag_keeps: assert property (irq && !cw ##1 timer_irq_enable |-> irq)
		else $error("irq dropped");
	a_flag_sets: assert property (fs ##1 timer_irq_enable |-> irq)
		else $error("flag write gave no irq");
	a_flag_reads: assert property (fs ##1 cr |=> sfr_rdata[CTL_HIGH_FLAG])
		else $error("flag not read back");
	a_reload_back: assert property (sfr_wr && sfr_addr == ADDR_RELOAD_LOW ##1
		sfr_rd && sfr_addr == ADDR_RELOAD_LOW |=> sfr_rdata == $past(sfr_wdata, 2))
		else $error("reload low readback");
	cover property (irq);
	cover property (cw ##1 cr);
	cover property (sfr_rd && un);
endmodule
bind arts_timer arts_chk i_chk (.clk(clk), .reset(reset), .sfr_addr(sfr_addr),
	.sfr_wr(sfr_wr), .sfr_wdata(sfr_wdata), .sfr_rd(sfr_rd), .sfr_rdata(sfr_rdata),
	.timer_irq_enable(timer_irq_enable), .irq(irq));
`default_nettype wire

// ===== tb/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
	import arts_pkg::*;
	logic clk = 1'h0, reset = 1'h1, wr = 1'h0, rd = 1'h0;
	logic hs = 1'h1, ls = 1'h1, ce = 1'h0, ie = 1'h0, xc = 1'h0;
	logic [7:0] a = 8'h00, wd = 8'h00, er, rdata;
	// model registers by address 0x90+i: 1 control, 2/3 reload, 4/5 count
	logic [7:0] m [8];
	logic [3:0] p;
	logic [2:0] sy = 3'h0, ec;
	wire irq;
	int mismatches = 0, compares = 0, seed = 4;
	arts_timer i_dut (.clk(clk), .reset(reset), .sfr_addr(a), .sfr_wr(wr), .sfr_wdata(wd),
		.sfr_rd(rd), .sfr_rdata(rdata), .high_byte_clock_select(hs),
		.low_byte_clock_select(ls), .capture_enable(ce), .timer_irq_enable(ie),
		.ext_clock(xc), .irq(irq));
	always #10 clk = ~clk;
	// external clock is asynchronous and well below half the system clock;
	// non-blocking so a toggle that meets a clock edge looks the same to both sides
	always #37 xc <= ~xc;
	wire rise = sy[1] & ~sy[2];
	wire pt = m[1][0] ? rise & ec == 3'h7 : p == SYS_DIV_LAST;
	wire tl = (ls | pt) & (m[1][3] ? !ce : m[1][2]);
	wire th = (hs | pt) & m[1][3] & m[1][2] & !ce;
	wire lw = m[4] == 8'hff;
	wire hw = m[5] == 8'hff;
	wire hc = th | tl & !m[1][3] & lw;
	wire hit = a[7:3] == 5'h12;
	always @(posedge clk) begin
		sy <= reset ? 3'h0 : {sy[1:0], xc};
		p <= (reset | p == SYS_DIV_LAST) ? 4'h0 : p + 4'h1;
		ec <= reset ? 3'h0 : ec + 3'(rise);
		if (rd) er <= hit ? m[a[2:0]] : 8'h00;
		if (reset) m <= '{default: 8'h00};
		else begin
			// hardware flag sets come after the control write so they win
			if (wr & hit & a[2:0] == 3'h1) m[1] <= wd & 8'hed;
			if (tl) m[4] <= lw & (m[1][3] | hw) ? m[2] : m[4] + 8'h1;
			if (tl & lw) m[1][6] <= 1'h1;
			if (hc) m[5] <= hw ? m[3] : m[5] + 8'h1;
			if (hc & hw) m[1][7] <= 1'h1;
			if (wr & hit & a[2:0] > 3'h1 & a[2:0] < 3'h6) m[a[2:0]] <= wd;
		end
	end
	task chk(input string n, input logic [7:0] s, e);
		compares++;
		if (s !== e) begin
			mismatches++;
			$display("BAD %s exp %h got %h", n, e, s);
		end
	endtask
	task end_of_test;
		$display("compares %0d mismatches %0d", compares, mismatches);
		if (mismatches == 0 && compares > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask
	task cyc(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	// one bus cycle; a read issued by the previous call is checked here
	task op(input logic w_, r_, input logic [7:0] ad, d);
		if (rd) chk("rdata", rdata, er);
		wr = w_;
		rd = r_;
		a = ad;
		wd = d;
		cyc(1);
	endtask
	always @(negedge clk) begin
		if (!reset) chk("irq", 8'(irq), 8'(ie & (m[1][7] | m[1][5] & m[1][6])));
	end
	initial begin
		#300000;
		mismatches++;
		end_of_test;
	end
	initial begin
		repeat (8) @(posedge clk);
		#1 reset = 1'h0;
		ie = 1'h1;
		for (int i = 0; i < 8; i++) op(1'h0, 1'h1, 8'h90 + 8'(i), 8'h00);
		op(1'h1, 1'h0, 8'h92, 8'($random(seed)));
		op(1'h0, 1'h1, 8'h92, 8'h00);
		op(1'h1, 1'h0, 8'h91, 8'hff);
		op(1'h0, 1'h1, 8'h91, 8'h00);
		for (int k = 0; k < 24; k++) begin
			{ie, hs, ls, ce} = 4'($random(seed));
			op(1'h1, 1'h0, 8'h95, 8'hff);
			op(1'h1, 1'h0, 8'h94, 8'hf0);
			op(1'h1, 1'h0, 8'h93, 8'($random(seed)));
			op(1'h1, 1'h0, 8'h96, 8'hff);
			op(1'h1, 1'h0, 8'h91, 8'($random(seed)));
			repeat (20) begin
				op(1'h0, 1'h1, 8'h90 + 8'($random(seed) & 7), 8'h00);
				op(1'h0, 1'h0, 8'h00, 8'h00);
				cyc(8);
			end
		end
		end_of_test;
	end
endmodule
`default_nettype wire
